// file: lelc_params.svh
// Offsets, field positions, reset values and counts for the link error / lock register bank.
// Assumes inclusion by bare name from the package and modules.
`ifndef LELC_PARAMS_SVH
`define LELC_PARAMS_SVH
`define LELC_OFS_LINK_ERR    8'hB9
`define LELC_OFS_ENC_CRC     8'hBA
`define LELC_OFS_SPARE_BB    8'hBB
`define LELC_OFS_FV_MIN      8'hBC
`define LELC_OFS_SPARE_BD    8'hBD
`define LELC_OFS_PULLDOWN    8'hBE
`define LELC_OFS_SPARE_BF    8'hBF
`define LELC_BIT_WAIT_IGN    5
`define LELC_BIT_CNT_EN      4
`define LELC_THR_MSB         3
`define LELC_BIT_CRC_DIS     7
`define LELC_RST_WAIT_IGN    1'h1
`define LELC_RST_CNT_EN      1'h1
`define LELC_RST_THRESH      4'h3
`define LELC_RST_CRC_DIS     1'h1
`define LELC_RST_ENC_LOW     7'h03
`define LELC_RST_FV_MIN      8'h00
`define LELC_RST_SPARE_BB    8'h74
`define LELC_RST_SPARE_BD    8'h00
`define LELC_RST_PULLDOWN    7'h00
`define LELC_RST_SPARE_BF    8'h00
`define LELC_PIN_COUNT       7
`endif

// file: lelc_pkg.sv
// Types shared by the link error / lock register bank and its frame-start gate.
// Assumes lelc_params.svh is on the include path.
`include "lelc_params.svh"
package lelc_pkg;
	// Register write/read request from the control port
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} lelc_req_t;
	// Forward-link error indications, one cycle each
	typedef struct packed {
		logic parity_err;
		logic clock_err;
		logic ctrl_err;
	} lelc_link_err_t;
	typedef enum logic [1:0] {
		LELC_UNLOCKED,
		LELC_LOCKED
	} lelc_lock_t;
	typedef enum logic [1:0] {
		LELC_FV_IDLE,
		LELC_FV_COUNT,
		LELC_FV_SENT
	} lelc_fv_t;
endpackage

// file: lelc_fs_gate.sv
// Frame-start gate for raw input mode: waits for a minimum frame-valid duration.
// Assumes frame_valid is synchronous to the pixel clock, one tick per link clock period.
`timescale 1ns/1ps
module lelc_fs_gate
	import lelc_pkg::*;
#(
	parameter int WIDTH = 8
)
(
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	// Control
	input  wire logic             raw_mode,
	input  wire logic [WIDTH-1:0] min_time,
	input  wire logic             frame_valid_signal,
	// Result
	output logic                  frame_start_pulse
);
	typedef struct packed {
		lelc_fv_t         st;
		logic [WIDTH-1:0] cnt;
		logic             pulse;
	} lelc_fs_state_t;
	lelc_fs_state_t state_ff;
	lelc_fs_state_t nxt_state;
	always_comb
	begin
		nxt_state = state_ff;
		nxt_state.pulse = 1'b0;
		case (state_ff.st)
			LELC_FV_IDLE:
			begin
				nxt_state.cnt = '0;
				if (frame_valid_signal && raw_mode)
					nxt_state.st = LELC_FV_COUNT;
			end
			LELC_FV_COUNT:
			begin
				// Counts cycles already held active; start once minimum reached
				if (!frame_valid_signal)
					nxt_state.st = LELC_FV_IDLE;
				else if (WIDTH'(state_ff.cnt + 1'b1) >= min_time || state_ff.cnt == '1)
				begin
					nxt_state.pulse = 1'b1;
					nxt_state.st = LELC_FV_SENT;
				end
				else
					nxt_state.cnt = WIDTH'(state_ff.cnt + 1'b1);
			end
			LELC_FV_SENT:
			begin
				if (!frame_valid_signal)
					nxt_state.st = LELC_FV_IDLE;
			end
			default:
				nxt_state.st = LELC_FV_IDLE;
		endcase
	end
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			state_ff <= '{st: LELC_FV_IDLE, cnt: '0, pulse: 1'b0};
		else
			state_ff <= nxt_state;
	end
	assign frame_start_pulse = state_ff.pulse;
endmodule

// file: lelc_regs.sv
// Link error / lock control register bank with error counter and pulldown control.
// Assumes clk_sys is the recovered pixel clock, the control port delivers one-cycle
// strobes on the same clock, and link error inputs are synchronous one-cycle pulses.
// Function
// - Ignore-bit set: errors during filter wait window are discarded by lock detection.
// - Count-enable bit, reset 1, lets link errors accumulate in the counter.
// - Counting enabled: lock lost when counter reaches 4-bit threshold, reset 3.
// - Counting disabled: first link error drops lock regardless of threshold.
// - Encoder control bit 7: 0 enables packet CRC check, resets to 1.
// - With CRC checking on, failed packets never update stored link information.
// - Raw mode: frame-start only after frame-valid held minimum link clock periods.
// - Pulldown on automatically when pin not output, unless disable bit set.
// - Seven pulldown disable bits, positions 6..0, reset 0.
`timescale 1ns/1ps
`include "lelc_params.svh"
module lelc_regs
	import lelc_pkg::*;
#(
	parameter int PINS = `LELC_PIN_COUNT
)
(
	// Clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 rst_n,
	// Register access from the control port
	input  lelc_pkg::lelc_req_t       req,
	output logic [7:0]                rdata,
	output logic                      rvalid,
	// Forward link status
	input  lelc_pkg::lelc_link_err_t  link_err,
	input  wire logic                 link_lock_raw,
	input  wire logic                 filter_wait_active,
	output logic                      lock_out,
	// Encoded link packets
	input  wire logic                 pkt_valid,
	input  wire logic                 pkt_crc_ok,
	input  wire logic [7:0]           pkt_info,
	output logic [7:0]                link_info,
	// Raw mode frame start
	input  wire logic                 raw_mode,
	input  wire logic                 frame_valid_signal,
	output logic                      frame_start,
	// Pin pulldowns
	input  wire logic [PINS-1:0]      pin_output_mode,
	output logic [PINS-1:0]           pin_pulldown_en
);
	typedef struct packed {
		logic            wait_ign;
		logic            cnt_en;
		logic [3:0]      thresh;
		logic            crc_dis;
		logic [6:0]      enc_low;
		logic [7:0]      spare_bb;
		logic [7:0]      fv_min;
		logic [7:0]      spare_bd;
		logic [PINS-1:0] pd_dis;
		logic [7:0]      spare_bf;
		logic [3:0]      err_cnt;
		lelc_lock_t      lock;
		logic [7:0]      info;
		logic [7:0]      rdata;
		logic            rvalid;
		logic [PINS-1:0] pd_en;
		logic            lock_flag;
	} lelc_state_t;
	lelc_state_t state_ff;
	lelc_state_t nxt_state;
	logic        fs_pulse;

	// Reserved bits and unmapped offsets read as zero
	function automatic logic [7:0] read_mux(input lelc_state_t s, input logic [7:0] a);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			`LELC_OFS_LINK_ERR: v = {2'b00, s.wait_ign, s.cnt_en, s.thresh};
			`LELC_OFS_ENC_CRC:  v = {s.crc_dis, s.enc_low};
			`LELC_OFS_SPARE_BB: v = s.spare_bb;
			`LELC_OFS_FV_MIN:   v = s.fv_min;
			`LELC_OFS_SPARE_BD: v = s.spare_bd;
			`LELC_OFS_PULLDOWN: v = 8'(s.pd_dis);
			`LELC_OFS_SPARE_BF: v = s.spare_bf;
			default:            v = 8'h00;
		endcase
		return v;
	endfunction

	// Combinational helpers, recomputed every cycle
	logic any_err;
	logic counted_err;
	always_comb
	begin
		nxt_state = state_ff;
		nxt_state.rvalid = req.rd;
		// Read sees the old value when a write hits the same cycle
		nxt_state.rdata = req.rd ? read_mux(state_ff, req.addr) : state_ff.rdata;
		if (req.wr)
		begin
			case (req.addr)
				`LELC_OFS_LINK_ERR:
				begin
					nxt_state.wait_ign = req.wdata[`LELC_BIT_WAIT_IGN];
					nxt_state.cnt_en = req.wdata[`LELC_BIT_CNT_EN];
					nxt_state.thresh = req.wdata[`LELC_THR_MSB:0];
				end
				`LELC_OFS_ENC_CRC:
				begin
					nxt_state.crc_dis = req.wdata[`LELC_BIT_CRC_DIS];
					nxt_state.enc_low = req.wdata[6:0];
				end
				`LELC_OFS_SPARE_BB: nxt_state.spare_bb = req.wdata;
				`LELC_OFS_FV_MIN:   nxt_state.fv_min = req.wdata;
				`LELC_OFS_SPARE_BD: nxt_state.spare_bd = req.wdata;
				`LELC_OFS_PULLDOWN: nxt_state.pd_dis = req.wdata[PINS-1:0];
				`LELC_OFS_SPARE_BF: nxt_state.spare_bf = req.wdata;
				default: ;
			endcase
		end

		// All three forward-channel error kinds feed one counter
		any_err = link_err.parity_err | link_err.clock_err | link_err.ctrl_err;
		counted_err = any_err && !(state_ff.wait_ign && filter_wait_active);

		// Errors while unlocked are not counted; acquisition starts from zero
		case (state_ff.lock)
			LELC_UNLOCKED:
			begin
				if (link_lock_raw)
				begin
					nxt_state.lock = LELC_LOCKED;
					nxt_state.err_cnt = 4'h0;
				end
			end
			LELC_LOCKED:
			begin
				if (!link_lock_raw)
				begin
					nxt_state.lock = LELC_UNLOCKED;
					nxt_state.err_cnt = 4'h0;
				end
				else if (counted_err)
				begin
					if (!state_ff.cnt_en)
					begin
						nxt_state.lock = LELC_UNLOCKED;
						nxt_state.err_cnt = 4'h0;
					end
					else if (4'(state_ff.err_cnt + 1'b1) >= state_ff.thresh
						|| state_ff.err_cnt == 4'hF)
					begin
						// Threshold of 0 or 1 drops on the first counted error
						nxt_state.lock = LELC_UNLOCKED;
						nxt_state.err_cnt = 4'h0;
					end
					else
						nxt_state.err_cnt = 4'(state_ff.err_cnt + 1'b1);
				end
			end
			default:
				nxt_state.lock = LELC_UNLOCKED;
		endcase
		// Lock kept as its own flop so lock_out needs no decode
		nxt_state.lock_flag = (nxt_state.lock == LELC_LOCKED);

		// Packets failing CRC are dropped only while checking is enabled
		if (pkt_valid && (state_ff.crc_dis || pkt_crc_ok))
			nxt_state.info = pkt_info;

		// An output pin never gets the pulldown, whatever the disable bit
		nxt_state.pd_en = ~pin_output_mode & ~state_ff.pd_dis;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_ff <= '{
				wait_ign: `LELC_RST_WAIT_IGN,
				cnt_en:   `LELC_RST_CNT_EN,
				thresh:   `LELC_RST_THRESH,
				crc_dis:  `LELC_RST_CRC_DIS,
				enc_low:  `LELC_RST_ENC_LOW,
				spare_bb: `LELC_RST_SPARE_BB,
				fv_min:   `LELC_RST_FV_MIN,
				spare_bd: `LELC_RST_SPARE_BD,
				pd_dis:   PINS'(`LELC_RST_PULLDOWN),
				spare_bf: `LELC_RST_SPARE_BF,
				err_cnt:  4'h0,
				lock:     LELC_UNLOCKED,
				info:     8'h00,
				rdata:    8'h00,
				rvalid:   1'b0,
				// Pulldowns off until the first edge samples the pin modes
				pd_en:    '0,
				lock_flag: 1'b0
			};
		end
		else
			state_ff <= nxt_state;
	end

	// Registered gate so frame_start is a flop output
	lelc_fs_gate #(
		.WIDTH(8)
	) u_fs_gate (
		.clk_sys            (clk_sys),
		.rst_n              (rst_n),
		.raw_mode           (raw_mode),
		.min_time           (state_ff.fv_min),
		.frame_valid_signal (frame_valid_signal),
		.frame_start_pulse  (fs_pulse)
	);

	assign rdata           = state_ff.rdata;
	assign rvalid          = state_ff.rvalid;
	assign lock_out        = state_ff.lock_flag;
	assign link_info       = state_ff.info;
	assign frame_start     = fs_pulse;
	assign pin_pulldown_en = state_ff.pd_en;
endmodule

// file: lelc_props.sv
// Checker bound into lelc_regs, watching its lock, read, frame-start and pulldown ports.
// Assumes the one clk_sys domain and the lelc_pkg port types.
`timescale 1ns/1ps
module lelc_props
#(
	parameter int PINS = 7
)
(
	// Clock and reset
	input wire logic                clk_sys,
	input wire logic                rst_n,
	// Watched ports
	input lelc_pkg::lelc_req_t      req,
	input wire logic                rvalid,
	input lelc_pkg::lelc_link_err_t link_err,
	input wire logic                link_lock_raw,
	input wire logic                lock_out,
	input wire logic                raw_mode,
	input wire logic                frame_valid_signal,
	input wire logic                frame_start,
	input wire logic [PINS-1:0]     pin_output_mode,
	input wire logic [PINS-1:0]     pin_pulldown_en
);
	import lelc_pkg::*;
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	chk_read_answer: assert property (rvalid == $past(req.rd))
		else $error("read answer missing or spurious");
	chk_pulldown_output: assert property ((pin_pulldown_en & $past(pin_output_mode)) == '0)
		else $error("pulldown on for an output pin");
	chk_drop_cause: assert property ($fell(lock_out) |-> $past(|link_err || !link_lock_raw))
		else $error("lock dropped without a link error");
	chk_quiet_hold: assert property (lock_out && link_lock_raw && link_err == '0 |=> lock_out)
		else $error("lock lost on a clean cycle");
	chk_relock_next: assert property (!lock_out && link_lock_raw |=> lock_out)
		else $error("lock not regained");
	chk_fs_held: assert property (frame_start |-> $past(frame_valid_signal, 2))
		else $error("frame start without frame valid");
	chk_fs_raw: assert property (frame_start |-> $past(raw_mode, 2))
		else $error("frame start outside raw mode");
	chk_fs_single: assert property (frame_start |=> !frame_start)
		else $error("frame start longer than one cycle");
endmodule
bind lelc_regs lelc_props #(.PINS(PINS)) u_props (.clk_sys, .rst_n, .req, .rvalid, .link_err,
	.link_lock_raw, .lock_out, .raw_mode, .frame_valid_signal, .frame_start,
	.pin_output_mode, .pin_pulldown_en);

// file: lelc_ser_model.sv
// Serializer stand-in: link errors, lock, packets and frame valid.
// Assumes the bench calls its tasks; changes land 1 ns after clk_sys rises.
`timescale 1ns/1ps
module lelc_ser_model
(
	// Clock
	input wire logic                 clk_sys,
	// Forward link
	output lelc_pkg::lelc_link_err_t link_err,
	output logic                     link_lock_raw,
	output logic                     pkt_valid,
	output logic                     pkt_crc_ok,
	output logic [7:0]               pkt_info,
	output logic                     frame_valid_signal
);
	import lelc_pkg::*;
	initial
	begin
		link_err = '0;
		link_lock_raw = 1'b1;
		{pkt_valid, pkt_crc_ok, pkt_info} = {1'b0, 1'b0, 8'h00};
		frame_valid_signal = 1'b0;
	end
	// Receiver loses lock for n edges, then acquires again
	task automatic unlock(input int n);
		tick(1);
		link_lock_raw = 1'b0;
		tick(n);
		link_lock_raw = 1'b1;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic errs(input int n, input logic [2:0] kind);
		repeat (n)
		begin
			tick(1);
			link_err = lelc_link_err_t'(kind);
		end
		tick(1);
		link_err = '0;
	endtask
	task automatic pkt(input logic [7:0] v, input logic ok);
		tick(1);
		{pkt_valid, pkt_crc_ok, pkt_info} = {1'b1, ok, v};
		tick(1);
		// Scrambled off the strobe, so stale data never passes for new
		{pkt_valid, pkt_crc_ok, pkt_info} = {1'b0, ~ok, ~v};
	endtask
	task automatic frame(input int n);
		tick(1);
		frame_valid_signal = 1'b1;
		tick(n);
		frame_valid_signal = 1'b0;
	endtask
endmodule

// file: tb.sv
// Bench for lelc_regs: register model, lock, packet, frame and pulldown checks.
// Assumes lelc_ser_model on the link side and lelc_props bound in.
`timescale 1ns/1ps
module tb;
	import lelc_pkg::*;
	lelc_req_t      req;
	lelc_link_err_t link_err;
	logic           clk_sys = 1'b0, rst_n, raw_mode, filter_wait_active;
	logic           link_lock_raw, pkt_valid, pkt_crc_ok, frame_valid_signal, rvalid, ok;
	logic           lock_out, frame_start;
	logic [6:0]     pin_output_mode, pin_pulldown_en, dis;
	logic [7:0]     pkt_info, link_info, rdata, v, info, mdl [logic [7:0]];
	logic [7:0]     rst_mdl [logic [7:0]];
	int             n_errors = 0, check_count = 0, cyc = 0, n_drop = 0, n_fs = 0, d, m;
	always #25 clk_sys = ~clk_sys;
	always @(negedge lock_out) n_drop++;
	always @(posedge clk_sys)
	begin
		n_fs += int'(frame_start === 1'b1);
		if (++cyc == 4000)
		begin
			n_errors++;
			finish_test();
		end
	end
	lelc_regs dut (.clk_sys, .rst_n, .req, .rdata, .rvalid, .link_err, .link_lock_raw,
		.filter_wait_active, .lock_out, .pkt_valid, .pkt_crc_ok, .pkt_info, .link_info,
		.raw_mode, .frame_valid_signal, .frame_start, .pin_output_mode, .pin_pulldown_en);
	lelc_ser_model ser (.clk_sys, .link_err, .link_lock_raw, .pkt_valid, .pkt_crc_ok,
		.pkt_info, .frame_valid_signal);
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] x);
		ser.tick(1);
		req = '{w, !w, a, x};
		ser.tick(1);
		req = '0;
		chk8({7'h00, rvalid}, {7'h00, !w});
		if (w && mdl.exists(a))
			mdl[a] = x & (a == 8'hB9 ? 8'h3F : a == 8'hBE ? 8'h7F : 8'hFF);
		if (!w)
			chk8(rdata, mdl.exists(a) ? mdl[a] : 8'h00);
	endtask
	task automatic finish_test();
		$display("checks %0d, mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		req = '0;
		rst_n = 1'b0;
		raw_mode = 1'b0;
		filter_wait_active = 1'b0;
		pin_output_mode = 7'h00;
		info = 8'h00;
		void'($urandom(32'hC194));
		rst_mdl = '{8'hB9: 8'h33, 8'hBA: 8'h83, 8'hBB: 8'h74, 8'hBC: 8'h00, 8'hBD: 8'h00,
			8'hBE: 8'h00, 8'hBF: 8'h00};
		mdl = rst_mdl;
		ser.tick(4);
		rst_n = 1'b1;
		ser.tick(1);
		chk8({1'b0, pin_pulldown_en}, 8'h7F);
		bus(1'b1, 8'h4C, 8'h01);
		for (int a = 8'hB8; a <= 8'hC0; a++)
			bus(1'b0, 8'(a), 8'h00);
		for (int a = 8'hB8; a <= 8'hC0; a++)
		begin
			bus(1'b1, 8'(a), 8'($urandom));
			bus(1'b0, 8'(a), 8'h00);
		end
		$display("test registers done");
		m = $urandom_range(15, 2);
		bus(1'b1, 8'hB9, 8'(8'h10 + m));
		for (int k = 0; k < 3; k++)
		begin
			d = n_drop;
			ser.errs(m - 1, 3'(1 << k));
			ser.tick(2);
			chk8(8'(n_drop - d), 8'h00);
			ser.errs(1, 3'(1 << k));
			ser.tick(2);
			chk8(8'(n_drop - d), 8'h01);
		end
		d = n_drop;
		bus(1'b1, 8'hB9, 8'h0F);
		ser.errs(1, 3'b001);
		ser.tick(2);
		chk8(8'(n_drop - d), 8'h01);
		bus(1'b1, 8'hB9, 8'h23);
		filter_wait_active = 1'b1;
		ser.errs(5, 3'b010);
		bus(1'b1, 8'hB9, 8'h03);
		ser.errs(1, 3'b100);
		ser.tick(2);
		filter_wait_active = 1'b0;
		chk8(8'(n_drop - d), 8'h02);
		d = n_drop;
		bus(1'b1, 8'hB9, 8'h13);
		ser.errs(2, 3'b001);
		ser.unlock(2);
		chk8({7'h00, lock_out}, 8'h00);
		ser.tick(1);
		chk8({7'h00, lock_out}, 8'h01);
		ser.errs(2, 3'b100);
		ser.tick(2);
		chk8(8'(n_drop - d), 8'h01);
		ser.errs(1, 3'b010);
		ser.tick(2);
		chk8(8'(n_drop - d), 8'h02);
		$display("test lock done");
		for (int k = 0; k < 8; k++)
		begin
			if (k % 4 == 0)
				bus(1'b1, 8'hBA, {k < 4, 7'h03});
			if (k == 4)
				bus(1'b1, 8'h4A, 8'h10);
			// Fresh value every packet; a CRC failure in each mode
			v = info ^ 8'($urandom_range(255, 1));
			ok = k[1] ? 1'($urandom) : k[0];
			ser.pkt(v, ok);
			if (k < 4 || ok)
				info = v;
			chk8(link_info, info);
		end
		$display("test packets done");
		for (int k = 0; k < 6; k++)
		begin
			m = $urandom_range(12, 2);
			raw_mode = (k != 5);
			bus(1'b1, 8'hBC, 8'(m));
			d = n_fs;
			// Odd frames hold exactly M+1 sampled edges, even ones one fewer
			ser.frame(k[0] ? m + 1 : m);
			ser.tick(3);
			chk8(8'(n_fs - d), {7'h00, raw_mode & k[0]});
		end
		$display("test frames done");
		for (int k = 0; k < 4; k++)
		begin
			dis = 7'($urandom);
			pin_output_mode = 7'($urandom);
			bus(1'b1, 8'hBE, {1'b1, dis});
			ser.tick(1);
			chk8({1'b0, pin_pulldown_en}, {1'b0, ~pin_output_mode & ~dis});
			bus(1'b0, 8'hBE, 8'h00);
		end
		$display("test pulldowns done");
		rst_n = 1'b0;
		ser.tick(2);
		rst_n = 1'b1;
		mdl = rst_mdl;
		ser.tick(1);
		chk8({1'b0, pin_pulldown_en}, {1'b0, ~pin_output_mode});
		chk8({7'h00, lock_out}, 8'h01);
		for (int a = 8'hB8; a <= 8'hC0; a++)
			bus(1'b0, 8'(a), 8'h00);
		$display("test reset done");
		finish_test();
	end
endmodule
